/* File: rtl/ctsc_top.sv */
// Control logic of the capacitive touch sensing unit.
`timescale 1ns/10ps
module ctsc_top
	import ctsc_pkg::*;
#(
	parameter int NUM_CHANNELS = 16
)
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_STROBE,
	input wire logic RD_STROBE,
	output logic [7:0] RD_DATA,
	input wire logic SENSE_OSC_CLOCK,
	input wire logic TIMER8_PIN_CLOCK,
	input wire logic TIMER16_PIN_CLOCK,
	input wire logic TIMER16_GATE,
	input wire logic SLEEP,
	output logic [15:0] SENSE_INPUT_PIN_SELECT,
	output logic OSC_RUN,
	output logic CURRENT_SOURCE_EN,
	output logic [1:0] OSC_CURRENT_RANGE,
	output logic REF_VARIABLE
);
	// ==========================================================
	// Parameter check
	if (NUM_CHANNELS < 1 || NUM_CHANNELS > 16)
		$error("NUM_CHANNELS must lie between 1 and 16.");

	// ==========================================================
	// Software visible state
	logic sense_unit_enable;
	logic reference_mode_select;
	logic [1:0] osc_current_range;
	logic timer8_ext_source_select;
	logic [3:0] sense_channel_select;
	logic timer8_source_select;
	logic timer8_overflow;
	logic [7:0] timer8_count;
	logic [1:0] timer16_clock_source;
	logic timer16_gate_enable;
	logic timer16_on;
	logic osc_source_sink_state;

	logic wr_pri;
	logic wr_sec;
	logic wr_t8opt;
	logic wr_t8cnt;
	logic wr_t16;

	assign wr_pri = WR_STROBE && ADDR == OFS_CTRL_PRI;
	assign wr_sec = WR_STROBE && ADDR == OFS_CTRL_SEC;
	assign wr_t8opt = WR_STROBE && ADDR == OFS_T8_OPT;
	assign wr_t8cnt = WR_STROBE && ADDR == OFS_T8_COUNT;
	assign wr_t16 = WR_STROBE && ADDR == OFS_T16_CTRL;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			sense_unit_enable <= 1'b0;
			reference_mode_select <= 1'b0;
			osc_current_range <= RANGE_OFF_NOISE;
			timer8_ext_source_select <= 1'b0;
		end
		else if (wr_pri)
		begin
			sense_unit_enable <= WR_DATA[POS_ENABLE];
			reference_mode_select <= WR_DATA[POS_REF_MODE];
			osc_current_range <= WR_DATA[POS_RANGE+:2];
			timer8_ext_source_select <= WR_DATA[POS_EXT_SEL];
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			sense_channel_select <= 4'h0;
		else if (wr_sec)
			sense_channel_select <= WR_DATA[3:0];
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			timer16_clock_source <= T16_CS_DIV4;
			timer16_gate_enable <= 1'b0;
			timer16_on <= 1'b0;
		end
		else if (wr_t16)
		begin
			timer16_clock_source <= WR_DATA[POS_T16_CS+:2];
			timer16_gate_enable <= WR_DATA[POS_T16_GATE_EN];
			timer16_on <= WR_DATA[POS_T16_ON];
		end
	end

	// ==========================================================
	// Synchronisers for the oscillator and the pins
	logic [1:0] osc_sync;
	logic [1:0] t8_pin_sync;
	logic [1:0] t16_pin_sync;
	logic [1:0] gate_sync;
	logic [1:0] sleep_sync;
	logic osc_last;
	logic t8_pin_last;
	logic t16_pin_last;
	logic osc_edge;
	logic t8_pin_edge;
	logic t16_pin_edge;

	// Only the second stage feeds logic, so a metastable first stage
	// never reaches the counters or the state bit.
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			osc_sync <= 2'h0;
			t8_pin_sync <= 2'h0;
			t16_pin_sync <= 2'h0;
			gate_sync <= 2'h0;
			sleep_sync <= 2'h0;
			osc_last <= 1'b0;
			t8_pin_last <= 1'b0;
			t16_pin_last <= 1'b0;
		end
		else
		begin
			osc_sync <= {osc_sync[0], SENSE_OSC_CLOCK};
			t8_pin_sync <= {t8_pin_sync[0], TIMER8_PIN_CLOCK};
			t16_pin_sync <= {t16_pin_sync[0], TIMER16_PIN_CLOCK};
			gate_sync <= {gate_sync[0], TIMER16_GATE};
			sleep_sync <= {sleep_sync[0], SLEEP};
			osc_last <= osc_sync[1];
			t8_pin_last <= t8_pin_sync[1];
			t16_pin_last <= t16_pin_sync[1];
		end
	end

	assign osc_edge = osc_sync[1] && !osc_last;
	assign t8_pin_edge = t8_pin_sync[1] && !t8_pin_last;
	assign t16_pin_edge = t16_pin_sync[1] && !t16_pin_last;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			osc_source_sink_state <= 1'b0;
		else
			osc_source_sink_state <= osc_sync[1];
	end

	// ==========================================================
	// Instruction rate divider
	logic [1:0] div4;
	logic div4_pulse;

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			div4 <= 2'h0;
		else
			div4 <= div4 + 2'h1;
	end

	assign div4_pulse = div4 == DIV4_LAST;

	// ==========================================================
	// Timer8 with clock source selection
	logic t8_pulse;

	// Timer8 stops in sleep, so it cannot measure while asleep.
	// The oscillator select bit wins over the source bit, so software
	// may leave the source bit clear while counting the oscillator.
	always_comb
	begin
		if (sleep_sync[1])
			t8_pulse = 1'b0;
		else if (timer8_ext_source_select)
			t8_pulse = osc_edge;
		else if (timer8_source_select)
			t8_pulse = t8_pin_edge;
		else
			t8_pulse = div4_pulse;
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			timer8_source_select <= 1'b0;
		else if (wr_t8opt)
			timer8_source_select <= WR_DATA[POS_T8_SRC];
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			timer8_count <= RST_REG;
		else if (wr_t8cnt)
			timer8_count <= WR_DATA;
		else if (t8_pulse)
			timer8_count <= timer8_count + 8'h01;
	end

	// A wrap in the same cycle as a clearing write still sets the flag.
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			timer8_overflow <= 1'b0;
		else if (t8_pulse && !wr_t8cnt && timer8_count == 8'hff)
			timer8_overflow <= 1'b1;
		else if (wr_t8opt && !WR_DATA[POS_T8_OVF])
			timer8_overflow <= 1'b0;
	end

	// ==========================================================
	// Timer16 with clock source selection
	ctsc_timer_if t16_bus ();
	logic t16_pulse;

	// The oscillator keeps clocking timer16 in sleep; only the
	// instruction rate and system clock sources stop there.
	always_comb
	begin
		case (timer16_clock_source)
			T16_CS_DIV4: t16_pulse = div4_pulse && !sleep_sync[1];
			T16_CS_SYS: t16_pulse = !sleep_sync[1];
			T16_CS_PIN: t16_pulse = t16_pin_edge;
			T16_CS_OSC: t16_pulse = osc_edge;
			default: t16_pulse = 1'b0;
		endcase
	end

	assign t16_bus.count_pulse = t16_pulse;
	assign t16_bus.gate_open = gate_sync[1];
	assign t16_bus.timer_on = timer16_on;
	assign t16_bus.gate_enable = timer16_gate_enable;
	assign t16_bus.write_lo = WR_STROBE && ADDR == OFS_T16_LO;
	assign t16_bus.write_hi = WR_STROBE && ADDR == OFS_T16_HI;
	assign t16_bus.write_data = WR_DATA;

	ctsc_timer16 u_timer16 (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.bus(t16_bus.tmr)
	);

	// ==========================================================
	// Analog control outputs
	logic [15:0] next_select;
	logic next_osc_run;
	logic next_current_en;

	always_comb
	begin
		next_select = 16'h0000;
		if (sense_unit_enable && 32'(sense_channel_select) < NUM_CHANNELS)
			next_select = 16'h0001 << sense_channel_select;
		// Variable mode code zero keeps comparators running for noise.
		next_osc_run = sense_unit_enable && (reference_mode_select
			|| osc_current_range != RANGE_OFF_NOISE);
		next_current_en = next_osc_run
			&& osc_current_range != RANGE_OFF_NOISE;
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SENSE_INPUT_PIN_SELECT <= 16'h0000;
			OSC_RUN <= 1'b0;
			CURRENT_SOURCE_EN <= 1'b0;
			OSC_CURRENT_RANGE <= RANGE_OFF_NOISE;
			REF_VARIABLE <= 1'b0;
		end
		else
		begin
			SENSE_INPUT_PIN_SELECT <= next_select;
			OSC_RUN <= next_osc_run;
			CURRENT_SOURCE_EN <= next_current_en;
			OSC_CURRENT_RANGE <= osc_current_range;
			REF_VARIABLE <= reference_mode_select;
		end
	end

	// ==========================================================
	// Read port
	logic [7:0] next_rd;

	always_comb
	begin
		next_rd = 8'h00;
		case (ADDR)
			OFS_CTRL_PRI: next_rd = {sense_unit_enable, reference_mode_select,
				2'h0, osc_current_range, osc_source_sink_state,
				timer8_ext_source_select};
			OFS_CTRL_SEC: next_rd = {4'h0, sense_channel_select};
			OFS_T8_OPT: next_rd = {2'h0, timer8_source_select, 4'h0,
				timer8_overflow};
			OFS_T8_COUNT: next_rd = timer8_count;
			OFS_T16_CTRL: next_rd = {timer16_clock_source, 4'h0,
				timer16_gate_enable, timer16_on};
			OFS_T16_LO: next_rd = t16_bus.count[7:0];
			OFS_T16_HI: next_rd = t16_bus.count[15:8];
			default: next_rd = 8'h00;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
			RD_DATA <= RST_REG;
		else if (RD_STROBE)
			RD_DATA <= next_rd;
		else
			RD_DATA <= RST_REG;
	end

	// ==========================================================
	// Checks
	a_disabled_no_channel: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) !sense_unit_enable
		|=> SENSE_INPUT_PIN_SELECT == 16'h0000)
		else $error("A channel is connected while the unit is off.");
	a_channel_one_hot: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) sense_unit_enable
		|=> SENSE_INPUT_PIN_SELECT == 16'h0001 << $past(sense_channel_select))
		else $error("Connected channel differs from the selected one.");
	a_reference_mode: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) wr_pri
		|=> ##1 REF_VARIABLE == $past(WR_DATA[POS_REF_MODE], 2))
		else $error("Reference mode output does not follow its bit.");
	a_fixed_range_off: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) !reference_mode_select
		&& osc_current_range == RANGE_OFF_NOISE |=> !OSC_RUN)
		else $error("Oscillator runs in fixed mode with range off.");
	a_noise_detect: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) sense_unit_enable && reference_mode_select
		&& osc_current_range == RANGE_OFF_NOISE
		|=> OSC_RUN && !CURRENT_SOURCE_EN)
		else $error("Noise detection mode drives the current source.");
	a_osc_state_sync: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) $rose(SENSE_OSC_CLOCK) ##1 SENSE_OSC_CLOCK[*2]
		|=> osc_source_sink_state)
		else $error("Oscillator state bit missed a steady level.");
	a_timer8_osc_count: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) timer8_ext_source_select
		&& osc_edge && !sleep_sync[1] && !wr_t8cnt
		|=> timer8_count == $past(timer8_count) + 8'h01)
		else $error("Timer8 missed an oscillator edge.");
	a_read_one_cycle: assert property (@(posedge REF_CLK)
		disable iff (!RST_N) RD_STROBE && ADDR == OFS_CTRL_PRI
		|=> RD_DATA[POS_OSC_STATE] == $past(osc_source_sink_state)
		##1 ($past(RD_STROBE) || RD_DATA == 8'h00))
		else $error("Read data wrong or held too long.");
endmodule

/* File: common/ctsc_pkg.sv */
// Package of constants shared by the touch sense control block.
package ctsc_pkg;
	localparam int ADDR_W = 3;
	// Register offsets, one byte wide register per address.
	localparam logic [2:0] OFS_CTRL_PRI = 3'h0;
	localparam logic [2:0] OFS_CTRL_SEC = 3'h1;
	localparam logic [2:0] OFS_T8_OPT = 3'h2;
	localparam logic [2:0] OFS_T8_COUNT = 3'h3;
	localparam logic [2:0] OFS_T16_CTRL = 3'h4;
	localparam logic [2:0] OFS_T16_LO = 3'h5;
	localparam logic [2:0] OFS_T16_HI = 3'h6;
	// Primary control field positions.
	localparam int POS_ENABLE = 7;
	localparam int POS_REF_MODE = 6;
	localparam int POS_RANGE = 2;
	localparam int POS_OSC_STATE = 1;
	localparam int POS_EXT_SEL = 0;
	// Timer8 option field positions.
	localparam int POS_T8_SRC = 5;
	localparam int POS_T8_OVF = 0;
	// Timer16 control field positions.
	localparam int POS_T16_CS = 6;
	localparam int POS_T16_GATE_EN = 1;
	localparam int POS_T16_ON = 0;
	// Reset values.
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	// Current range and timer16 clock source codes.
	localparam logic [1:0] RANGE_OFF_NOISE = 2'h0;
	localparam logic [1:0] T16_CS_DIV4 = 2'h0;
	localparam logic [1:0] T16_CS_SYS = 2'h1;
	localparam logic [1:0] T16_CS_PIN = 2'h2;
	localparam logic [1:0] T16_CS_OSC = 2'h3;
	// Instruction rate divider: one pulse every four system clocks.
	localparam logic [1:0] DIV4_LAST = 2'h3;
endpackage

/* File: common/ctsc_timer_if.sv */
// Interface between the control logic and the 16-bit timer.
`timescale 1ns/10ps
interface ctsc_timer_if;
	logic count_pulse;
	logic gate_open;
	logic timer_on;
	logic gate_enable;
	logic write_lo;
	logic write_hi;
	logic [7:0] write_data;
	logic [15:0] count;
	modport ctl (output count_pulse, gate_open, timer_on, gate_enable,
		write_lo, write_hi, write_data, input count);
	modport tmr (input count_pulse, gate_open, timer_on, gate_enable,
		write_lo, write_hi, write_data, output count);
endinterface

/* File: rtl/ctsc_timer16.sv */
// Sixteen bit timer counted by selected clock pulses.
`timescale 1ns/10ps
module ctsc_timer16
	import ctsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	ctsc_timer_if.tmr bus
);
	// ==========================================================
	// Counter
	logic [15:0] count;
	logic run;

	// The gate is only honoured while gating is enabled.
	assign run = bus.timer_on && (!bus.gate_enable || bus.gate_open);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= RST_COUNT;
		else if (bus.write_lo)
			count[7:0] <= bus.write_data;
		else if (bus.write_hi)
			count[15:8] <= bus.write_data;
		else if (run && bus.count_pulse)
			count <= count + 16'h0001;
	end

	assign bus.count = count;

	// ==========================================================
	// Checks
	a_timer_off_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!bus.timer_on && !bus.write_lo && !bus.write_hi |=> $stable(count))
		else $error("Timer16 counted while switched off.");
	a_gate_closed_hold: assert property (@(posedge clk) disable iff (!rst_n)
		bus.gate_enable && !bus.gate_open && !bus.write_lo && !bus.write_hi
		|=> $stable(count))
		else $error("Timer16 counted with the gate closed.");
	a_free_run_step: assert property (@(posedge clk) disable iff (!rst_n)
		bus.timer_on && !bus.gate_enable && bus.count_pulse
		&& !bus.write_lo && !bus.write_hi
		|=> count == $past(count) + 16'h0001)
		else $error("Timer16 missed a count pulse while free running.");
endmodule

/* File: test/ctsc_pad_model.sv */
// Behavioural model of a touch pad hanging on the sensing oscillator.
`timescale 1ns/10ps
// ==========================================
// Pad model
module ctsc_pad_model #(
	parameter int HALF_NOM = 23,
	parameter int HALF_LOAD = 37
)
(
	input wire logic [15:0] sel,
	input wire logic osc_run,
	input wire logic current_en,
	input wire logic loaded,
	input wire logic noise,
	output logic osc_clk
);
	initial osc_clk = 1'b0;
	// A finger adds load, so the triangle wave slows down.
	always
	begin
		if (osc_run && current_en && (sel != 16'h0000))
		begin
			#(loaded ? HALF_LOAD : HALF_NOM) osc_clk = ~osc_clk;
		end
		else
		begin
			// With no current source the comparator only follows noise.
			osc_clk = osc_run & noise;
			#1;
		end
	end
endmodule

/* File: test/ctsc_top_tb_top.sv */
// Self-checking testbench of the touch sense control block.
`timescale 1ns/10ps
module ctsc_top_tb_top
	import ctsc_pkg::*;
;
	logic clk, rst_n, wr_s, rd_s, t8_pin, t16_gate, sleep, loaded, noise;
	logic t16_pin;
	logic [2:0] addr;
	logic [7:0] wdata, rdata;
	logic [15:0] sel;
	logic osc, run, cur, refv;
	logic [1:0] rng;
	int fails = 0;
	int num_checks = 0;

	ctsc_top DUT (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr),
		.WR_DATA(wdata), .WR_STROBE(wr_s), .RD_STROBE(rd_s),
		.RD_DATA(rdata), .SENSE_OSC_CLOCK(osc),
		.TIMER8_PIN_CLOCK(t8_pin), .TIMER16_PIN_CLOCK(t16_pin),
		.TIMER16_GATE(t16_gate), .SLEEP(sleep),
		.SENSE_INPUT_PIN_SELECT(sel), .OSC_RUN(run),
		.CURRENT_SOURCE_EN(cur), .OSC_CURRENT_RANGE(rng),
		.REF_VARIABLE(refv));
	ctsc_pad_model PAD (.sel(sel), .osc_run(run), .current_en(cur),
		.loaded(loaded), .noise(noise), .osc_clk(osc));

	// ==========================================
	// Clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		#200000;
		fails++;
		final_report();
	end

	// ==========================================
	// Shared tasks
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask
	// A tolerance absorbs the synchroniser lag at start and stop.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input logic [15:0] tol);
		num_checks++;
		if ($isunknown(got) || got + tol < exp || got > exp + tol)
		begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		logic [7:0] d;
		// Timer8 counts the instruction rate from reset, so one tick has
		// passed by the time its count is read.
		for (int a = 0; a < 8; a++)
		begin
			rd(a[2:0], d);
			chk({8'h00, d}, (a == 3) ? 16'h0001 : 16'h0000, 16'h0000);
		end
		chk(sel, 16'h0000, 16'h0000);
		wr(3'h7, 8'hff);
		rd(3'h7, d);
		chk({8'h00, d}, 16'h0000, 16'h0000);
		wr(3'h0, 8'h72);
		wr(3'h1, 8'hff);
		rd(3'h0, d);
		chk({8'h00, d}, 16'h0040, 16'h0000);
		rd(3'h1, d);
		chk({8'h00, d}, 16'h000f, 16'h0000);
	endtask
	task automatic t_mux();
		wr(3'h0, 8'h8c);
		for (int ch = 0; ch < 16; ch++)
		begin
			wr(3'h1, ch[7:0]);
			idle(2);
			chk(sel, 16'h0001 << ch, 16'h0000);
		end
		wr(3'h0, 8'h0c);
		idle(2);
		chk(sel, 16'h0000, 16'h0000);
		chk({15'h0, run | cur}, 16'h0000, 16'h0000);
	endtask
	task automatic t_range();
		for (int m = 0; m < 2; m++)
			for (int r = 0; r < 4; r++)
			begin
				wr(3'h0, {1'b1, m[0], 2'b00, r[1:0], 2'b00});
				idle(2);
				chk({12'h0, refv, rng, run}, {12'h0, m[0], r[1:0],
					m[0] | (r != 0)}, 16'h0000);
				chk({15'h0, cur}, {15'h0, r != 0}, 16'h0000);
			end
	endtask
	task automatic t_state();
		logic [7:0] d;
		wr(3'h1, 8'h00);
		wr(3'h0, 8'hc0);
		noise <= 1'b1;
		idle(12);
		rd(3'h0, d);
		chk({8'h00, d}, 16'h00c2, 16'h0000);
		noise <= 1'b0;
		idle(6);
		rd(3'h0, d);
		chk({8'h00, d}, 16'h00c0, 16'h0000);
	endtask
	task automatic meas(input logic ld, input logic [15:0] exp);
		logic [7:0] lo, hi;
		wr(3'h0, 8'h8c);
		loaded <= ld;
		wr(3'h5, 8'h00);
		wr(3'h6, 8'h00);
		wr(3'h4, 8'hc1);
		idle(400);
		wr(3'h4, 8'hc0);
		idle(6);
		rd(3'h5, lo);
		rd(3'h6, hi);
		chk({hi, lo}, exp, 16'h0002);
	endtask
	task automatic t_t16();
		logic [7:0] d;
		meas(1'b0, 16'd43);
		sleep <= 1'b1;
		meas(1'b1, 16'd27);
		sleep <= 1'b0;
		loaded <= 1'b0;
		wr(3'h5, 8'h00);
		wr(3'h4, 8'hc3);
		idle(100);
		rd(3'h5, d);
		chk({8'h00, d}, 16'h0000, 16'h0000);
		t16_gate <= 1'b1;
		idle(100);
		rd(3'h5, d);
		chk({8'h00, d}, 16'd10, 16'h0002);
		wr(3'h4, 8'hc2);
		wr(3'h5, 8'h00);
		idle(50);
		rd(3'h5, d);
		chk({8'h00, d}, 16'h0000, 16'h0000);
	endtask
	task automatic t_src();
		logic [7:0] d;
		// Timer16 from the instruction rate, every clock, then its pin.
		wr(3'h4, 8'h00);
		wr(3'h5, 8'h00);
		wr(3'h4, 8'h01);
		idle(40);
		wr(3'h4, 8'h00);
		rd(3'h5, d);
		chk({8'h00, d}, 16'd10, 16'h0001);
		wr(3'h5, 8'h00);
		wr(3'h4, 8'h41);
		idle(20);
		wr(3'h4, 8'h40);
		rd(3'h5, d);
		chk({8'h00, d}, 16'd22, 16'h0000);
		wr(3'h5, 8'h00);
		wr(3'h4, 8'h81);
		repeat (4)
		begin
			t16_pin <= 1'b1;
			idle(4);
			t16_pin <= 1'b0;
			idle(4);
		end
		idle(6);
		wr(3'h4, 8'h80);
		rd(3'h5, d);
		chk({8'h00, d}, 16'h0004, 16'h0000);
	endtask
	task automatic t_t8();
		logic [7:0] d;
		wr(3'h2, 8'h00);
		wr(3'h0, 8'h8d);
		wr(3'h3, 8'hfe);
		idle(100);
		wr(3'h0, 8'h8c);
		rd(3'h3, d);
		chk({8'h00, d}, 16'd9, 16'h0002);
		rd(3'h2, d);
		chk({8'h00, d}, 16'h0001, 16'h0000);
		wr(3'h2, 8'h21);
		wr(3'h3, 8'h00);
		idle(50);
		rd(3'h3, d);
		chk({8'h00, d}, 16'h0000, 16'h0000);
		repeat (3)
		begin
			t8_pin <= 1'b1;
			idle(4);
			t8_pin <= 1'b0;
			idle(4);
		end
		idle(6);
		rd(3'h3, d);
		chk({8'h00, d}, 16'h0003, 16'h0000);
		wr(3'h2, 8'h20);
		rd(3'h2, d);
		chk({8'h00, d}, 16'h0020, 16'h0000);
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		t8_pin = 1'b0;
		t16_pin = 1'b0;
		t16_gate = 1'b0;
		sleep = 1'b0;
		loaded = 1'b0;
		noise = 1'b0;
		idle(4);
		rst_n <= 1'b1;
		t_reset();
		t_mux();
		t_range();
		t_state();
		t_t16();
		t_src();
		t_t8();
		final_report();
	end
endmodule
